// *** core/owd_decode.v ***
`timescale 1ns/1ps
`include "owd_defs.vh"
module owd_decode #(
  parameter IW = 13
) (
  input  wire          mclk_i,
  input  wire          sys_rst_i,
  input  wire          opt_load_i,
  input  wire [12:0]   opt_word_i,
  input  wire          instr_valid_i,
  input  wire [IW-1:0] instr_i,
  input  wire          skip_true_i,
  input  wire          irq_pending_i,
  output reg           osc_type_select_o,
  output reg           watchdog_enable_o,
  output reg           long_cycle_o,
  output reg           code_protect_o,
  output reg           fast_crystal_mode_o,
  output reg           slow_crystal_mode_o,
  output reg           drive_power_select_o,
  output reg           variant_a_o,
  output reg           opt_reserved_err_o,
  output reg  [3:0]    customer_id_o,
  output reg           phase_o,
  output reg           cycle_end_o,
  output reg           timer_clk_en_o,
  output reg           instr_ready_o,
  output reg  [5:0]    reg_sel_o,
  output reg  [2:0]    bit_pos_o,
  output reg  [9:0]    literal_o,
  output reg           lit_wide_o,
  output reg           bit_clr_o,
  output reg           bit_set_o,
  output reg           bit_test_o,
  output reg           two_cycle_o,
  output reg           nop_o,
  output reg           decimal_adjust_op_o,
  output reg           ctrl_write_op_o,
  output reg           ctrl_read_op_o,
  output reg           io_ctrl_write_op_o,
  output reg           sleep_op_o,
  output reg           watchdog_clear_op_o,
  output reg           osc_stop_o,
  output reg           tout_flag_o,
  output reg           pdown_flag_o,
  output reg           irq_enable_op_o,
  output reg           irq_disable_op_o,
  output reg           ret_op_o,
  output reg           irq_return_op_o,
  output reg           gie_o,
  output reg           irq_vector_o,
  output reg  [12:0]   vector_addr_o
);
  reg  [12:0] opt_reg;
  reg  [1:0]  div_reg;
  reg         stall_reg;
  wire        cyc_done = opt_reg[`OWD_OPT_CYCLE_LEN] ? (div_reg == 2'h3) : div_reg[0];
  wire [IW-1:0] w = instr_i;
  wire        accept = instr_valid_i & cyc_done & ~stall_reg;

  // Ops that write their register field: rows with top bits 00 and the destination
  // bit set, plus bit clear and bit set. A-destination rows never count.
  function wr_to_reg;
    input [12:0] op;
    reg          row_dest;
    reg          bit_write;
    begin
      row_dest  = (op[12:11] == 2'h0) & op[6];
      bit_write = (op[12:11] == 2'h1) & ~op[10];
      wr_to_reg = row_dest | bit_write;
    end
  endfunction

  // Flow changes: calls, jumps, returns and the table jump
  function is_jump;
    input [12:0] op;
    begin
      is_jump = op[12] | (op == `OWD_OP_RET) | (op == `OWD_OP_IRQ_RETURN_OP)
                | (op == `OWD_OP_TABLE);
    end
  endfunction

  // Conditional skips: bit tests and the count-and-test rows
  function is_skip;
    input [12:0] op;
    reg          bit_test;
    reg          count_test;
    begin
      bit_test   = (op[12:10] == 3'h3);
      count_test = (op[12:7] == 6'h0B) | (op[12:7] == 6'h0F);
      is_skip    = bit_test | count_test;
    end
  endfunction

  // Wide literal for calls and jumps (top bit set), narrow for the rest, returns and the table jump included
  function [9:0] lit_field;
    input [12:0] op;
    begin
      if (op[12]) begin
        lit_field = op[9:0];
      end else begin
        lit_field = {2'h0, op[7:0]};
      end
    end
  endfunction

  // Bit clear row
  function is_bit_clr;
    input [12:0] op;
    begin
      is_bit_clr = (op[12:9] == 4'h4);
    end
  endfunction

  // Bit set row
  function is_bit_set;
    input [12:0] op;
    begin
      is_bit_set = (op[12:9] == 4'h5);
    end
  endfunction

  // Both bit test rows; the skip itself comes from the datapath
  function is_bit_test;
    input [12:0] op;
    begin
      is_bit_test = (op[12:10] == 3'h3);
    end
  endfunction

  // Word redirects the program counter, so the next cycle is a bubble
  wire        pc_write = wr_to_reg(w) && (w[5:0] == `OWD_PC_ADDR);
  wire        stretch  = pc_write || is_jump(w) || (skip_true_i && is_skip(w));


  // Option bits latched only by the programming interface
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opt_reg <= `OWD_OPT_RESET;
    end else if (opt_load_i) begin
      opt_reg <= opt_word_i;
    end
  end

  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      osc_type_select_o    <= 1'b0;
      watchdog_enable_o    <= 1'b0;
      long_cycle_o         <= 1'b0;
      code_protect_o       <= 1'b0;
      fast_crystal_mode_o  <= 1'b0;
      slow_crystal_mode_o  <= 1'b0;
      drive_power_select_o <= 1'b0;
      variant_a_o          <= 1'b0;
      opt_reserved_err_o   <= 1'b0;
      customer_id_o        <= 4'h0;
    end else begin
      osc_type_select_o    <= opt_reg[`OWD_OPT_OSC_TYPE];
      watchdog_enable_o    <= ~opt_reg[`OWD_OPT_WDT_DIS_N];
      long_cycle_o         <= opt_reg[`OWD_OPT_CYCLE_LEN];
      code_protect_o       <= ~opt_reg[`OWD_OPT_CODE_PROT];
      fast_crystal_mode_o  <= opt_reg[`OWD_OPT_OSC_TYPE] & opt_reg[`OWD_OPT_XTAL_RANGE];
      slow_crystal_mode_o  <= opt_reg[`OWD_OPT_OSC_TYPE] & ~opt_reg[`OWD_OPT_XTAL_RANGE]
                              & ~opt_reg[`OWD_OPT_DRIVE_PWR];
      // Drive bit has no meaning in fast crystal mode
      drive_power_select_o <= opt_reg[`OWD_OPT_DRIVE_PWR] & ~(opt_reg[`OWD_OPT_OSC_TYPE]
                              & opt_reg[`OWD_OPT_XTAL_RANGE]);
      variant_a_o          <= opt_reg[`OWD_OPT_VARIANT];
      // Flags bad programming; RC with range bit set is also wrong
      opt_reserved_err_o   <= ~opt_reg[`OWD_OPT_RSVD_HI] | opt_reg[`OWD_OPT_RSVD_LO]
                              | (~opt_reg[`OWD_OPT_OSC_TYPE] & opt_reg[`OWD_OPT_XTAL_RANGE]);
      customer_id_o        <= opt_reg[3:0];
    end
  end

  // Oscillator-period divider; timer enable follows the cycle length
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_reg        <= 2'h0;
      timer_clk_en_o <= 1'b0;
      cycle_end_o    <= 1'b0;
      phase_o        <= 1'b0;
    end else begin
      div_reg        <= opt_reg[`OWD_OPT_CYCLE_LEN] ? div_reg + 2'h1 : {1'b0, ~div_reg[0]};
      timer_clk_en_o <= cyc_done;
      cycle_end_o    <= cyc_done;
      phase_o        <= div_reg[0];
    end
  end

  always @* begin
    instr_ready_o = cyc_done & ~stall_reg;
  end

  // Decode registered at the end of each instruction cycle
  always @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stall_reg           <= 1'b0;
      reg_sel_o           <= 6'h00;
      bit_pos_o           <= 3'h0;
      literal_o           <= 10'h000;
      lit_wide_o          <= 1'b0;
      bit_clr_o           <= 1'b0;
      bit_set_o           <= 1'b0;
      bit_test_o          <= 1'b0;
      two_cycle_o         <= 1'b0;
      nop_o               <= 1'b0;
      decimal_adjust_op_o <= 1'b0;
      ctrl_write_op_o     <= 1'b0;
      ctrl_read_op_o      <= 1'b0;
      io_ctrl_write_op_o  <= 1'b0;
      sleep_op_o          <= 1'b0;
      watchdog_clear_op_o <= 1'b0;
      osc_stop_o          <= 1'b0;
      tout_flag_o         <= 1'b1;
      pdown_flag_o        <= 1'b1;
      irq_enable_op_o     <= 1'b0;
      irq_disable_op_o    <= 1'b0;
      ret_op_o            <= 1'b0;
      irq_return_op_o     <= 1'b0;
      gie_o               <= 1'b0;
      irq_vector_o        <= 1'b0;
      vector_addr_o       <= 13'h0000;
    end else begin
      nop_o               <= 1'b0;
      decimal_adjust_op_o <= 1'b0;
      ctrl_write_op_o     <= 1'b0;
      ctrl_read_op_o      <= 1'b0;
      io_ctrl_write_op_o  <= 1'b0;
      sleep_op_o          <= 1'b0;
      watchdog_clear_op_o <= 1'b0;
      irq_enable_op_o     <= 1'b0;
      irq_disable_op_o    <= 1'b0;
      ret_op_o            <= 1'b0;
      irq_return_op_o     <= 1'b0;
      irq_vector_o        <= 1'b0;
      bit_clr_o           <= 1'b0;
      bit_set_o           <= 1'b0;
      bit_test_o          <= 1'b0;
      if (cyc_done && stall_reg) begin
        stall_reg   <= 1'b0;
        two_cycle_o <= 1'b0;
      end else if (accept) begin
        reg_sel_o  <= w[5:0];
        bit_pos_o  <= w[8:6];
        literal_o  <= lit_field(w);
        lit_wide_o <= w[12] & ~w[11];
        bit_clr_o  <= is_bit_clr(w);
        bit_set_o  <= is_bit_set(w);
        bit_test_o <= is_bit_test(w);
        nop_o               <= w == `OWD_OP_NOP;
        decimal_adjust_op_o <= w == `OWD_OP_DAA;
        ctrl_write_op_o     <= w == `OWD_OP_CTRL_WR;
        ctrl_read_op_o      <= w == `OWD_OP_CTRL_RD;
        io_ctrl_write_op_o  <= w[12:4] == 9'h000 & w[3:0] > 4'h4;
        irq_enable_op_o     <= w == `OWD_OP_IRQ_EN;
        irq_disable_op_o    <= w == `OWD_OP_IRQ_DIS;
        ret_op_o            <= w == `OWD_OP_RET;
        irq_return_op_o     <= w == `OWD_OP_IRQ_RETURN_OP;
        if (w == `OWD_OP_SLEEP) begin
          sleep_op_o          <= 1'b1;
          osc_stop_o          <= 1'b1;
          tout_flag_o         <= 1'b1;
          pdown_flag_o        <= 1'b0;
        end
        if (w == `OWD_OP_WDT_CLR) begin
          watchdog_clear_op_o <= 1'b1;
          tout_flag_o         <= 1'b1;
          pdown_flag_o        <= 1'b1;
        end
        if (w == `OWD_OP_IRQ_EN || w == `OWD_OP_IRQ_RETURN_OP) begin
          gie_o <= 1'b1;
        end else if (w == `OWD_OP_IRQ_DIS) begin
          gie_o <= 1'b0;
        end
        if (stretch) begin
          stall_reg   <= 1'b1;
          two_cycle_o <= 1'b1;
        end else begin
          two_cycle_o <= 1'b0;
        end
      end else if (cyc_done && gie_o && irq_pending_i) begin
        // Interrupt taken between instructions; masks itself until re-enabled
        irq_vector_o  <= 1'b1;
        vector_addr_o <= `OWD_IRQ_VECTOR;
        gie_o         <= 1'b0;
      end
      // Sleep taken with a store in one cycle wins, so the stop is not lost
      if (opt_load_i && !(accept && w == `OWD_OP_SLEEP)) begin
        osc_stop_o <= 1'b0;
      end
    end
  end
endmodule // owd_decode

// *** core/owd_defs.vh ***
`ifndef OWD_DEFS_VH
`define OWD_DEFS_VH
`define OWD_OPT_OSC_TYPE    12
`define OWD_OPT_WDT_DIS_N   11
`define OWD_OPT_CYCLE_LEN   10
`define OWD_OPT_CODE_PROT   9
`define OWD_OPT_XTAL_RANGE  8
`define OWD_OPT_DRIVE_PWR   7
`define OWD_OPT_VARIANT     6
`define OWD_OPT_RSVD_HI     5
`define OWD_OPT_RSVD_LO     4
`define OWD_OPT_RESET       13'h1FFF
`define OWD_IRQ_VECTOR      13'h0001
`define OWD_OP_NOP          13'h0000
`define OWD_OP_DAA          13'h0001
`define OWD_OP_CTRL_WR      13'h0002
`define OWD_OP_SLEEP        13'h0003
`define OWD_OP_WDT_CLR      13'h0004
`define OWD_OP_IRQ_EN       13'h0010
`define OWD_OP_IRQ_DIS      13'h0011
`define OWD_OP_RET          13'h0012
`define OWD_OP_IRQ_RETURN_OP         13'h0013
`define OWD_OP_CTRL_RD      13'h0014
`define OWD_OP_TABLE        13'h0020
`define OWD_PC_ADDR         6'h02
`endif

// *** verif/owd_decode_sva.sv ***
`timescale 1ns/1ps
module owd_decode_sva (
  input wire logic        mclk_i,
  input wire logic        sys_rst_i,
  input wire logic        opt_load_i,
  input wire logic [12:0] opt_word_i,
  input wire logic        instr_valid_i,
  input wire logic [12:0] instr_i,
  input wire logic        instr_ready_o,
  input wire logic        osc_type_select_o,
  input wire logic        watchdog_enable_o,
  input wire logic        long_cycle_o,
  input wire logic        code_protect_o,
  input wire logic        fast_crystal_mode_o,
  input wire logic        slow_crystal_mode_o,
  input wire logic        sleep_op_o,
  input wire logic        pdown_flag_o,
  input wire logic        two_cycle_o,
  input wire logic [5:0]  reg_sel_o,
  input wire logic [2:0]  bit_pos_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // Outputs lag the store by one cycle, so judge three edges on
  sequence s_opt_loaded;
    opt_load_i ##1 !opt_load_i [*3];
  endsequence
  sequence s_take;
    instr_valid_i && instr_ready_o;
  endsequence
  a_osc_type_map: assert property (s_opt_loaded |->
    osc_type_select_o == $past(opt_word_i[12], 3)) else $error("osc type wrong");
  a_wdt_enable_map: assert property (s_opt_loaded |->
    watchdog_enable_o != $past(opt_word_i[11], 3)) else $error("watchdog enable wrong");
  a_cycle_len_map: assert property (s_opt_loaded |->
    long_cycle_o == $past(opt_word_i[10], 3)) else $error("cycle length wrong");
  a_code_prot_map: assert property (s_opt_loaded |->
    code_protect_o != $past(opt_word_i[9], 3)) else $error("protection wrong");
  a_fast_xtal_map: assert property (s_opt_loaded |-> fast_crystal_mode_o ==
    (($past(opt_word_i, 3) & 13'h1100) == 13'h1100)) else $error("fast crystal wrong");
  a_slow_xtal_map: assert property (s_opt_loaded |-> slow_crystal_mode_o ==
    (($past(opt_word_i, 3) & 13'h1180) == 13'h1000)) else $error("slow crystal wrong");
  a_sleep_flags: assert property (s_take ##0 instr_i == 13'h0003 |->
    ##1 sleep_op_o ##1 !pdown_flag_o) else $error("sleep effects wrong");
  a_two_cycle_ret: assert property (s_take ##0 instr_i == 13'h0012 |=>
    two_cycle_o) else $error("return not two cycles");
  a_field_split: assert property (s_take |=> reg_sel_o == $past(instr_i[5:0]) &&
    bit_pos_o == $past(instr_i[8:6])) else $error("operand fields wrong");
endmodule // owd_decode_sva

// *** verif/owd_prog_mem.sv ***
`timescale 1ns/1ps
module owd_prog_mem (
  input  wire logic        mclk_i,
  input  wire logic        load_i,
  input  wire logic [12:0] word_i,
  input  wire logic        skip_i,
  input  wire logic        ready_i,
  output logic             valid_o = 1'b0,
  output logic [12:0]      instr_o = 13'h1FFF,
  output logic             skip_o  = 1'b0,
  output logic             taken_o = 1'b0
);
  // Released word shows its inverse so a stale word never matches
  always @(posedge mclk_i) begin
    taken_o <= valid_o && ready_i;
    if (valid_o && ready_i) begin
      valid_o <= 1'b0;
      instr_o <= ~instr_o;
      skip_o  <= ~skip_o;
    end else if (load_i && !valid_o) begin
      valid_o <= 1'b1;
      instr_o <= word_i;
      skip_o  <= skip_i;
    end
  end
endmodule // owd_prog_mem

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, opt_load_i = 1'b0, irq_pending_i = 1'b0;
  logic mem_load = 1'b0, mem_skip = 1'b0, taken, instr_valid_i, skip_true_i;
  logic [12:0] opt_word_i = 13'h1FFF, mem_word = 13'h0000, instr_i, vector_addr_o;
  logic [9:0] literal_o;
  logic [5:0] reg_sel_o;
  logic [3:0] customer_id_o;
  logic [2:0] bit_pos_o;
  logic osc_type_select_o, watchdog_enable_o, long_cycle_o, code_protect_o, variant_a_o;
  logic fast_crystal_mode_o, slow_crystal_mode_o, drive_power_select_o, opt_reserved_err_o;
  logic phase_o, cycle_end_o, timer_clk_en_o, instr_ready_o, lit_wide_o, bit_clr_o, bit_set_o;
  logic bit_test_o, two_cycle_o, nop_o, decimal_adjust_op_o, ctrl_write_op_o, ctrl_read_op_o;
  logic io_ctrl_write_op_o, sleep_op_o, watchdog_clear_op_o, osc_stop_o, tout_flag_o, gie_o;
  logic pdown_flag_o, irq_enable_op_o, irq_disable_op_o, ret_op_o, irq_return_op_o, irq_vector_o;
  int n_errors = 0, total_checks = 0, cyc = 0, t_take = 0, t_prev = 0;
  owd_decode i_dut (.*);
  owd_prog_mem i_mem (.mclk_i(mclk_i), .load_i(mem_load), .word_i(mem_word), .skip_i(mem_skip),
    .ready_i(instr_ready_o), .valid_o(instr_valid_i), .instr_o(instr_i),
    .skip_o(skip_true_i), .taken_o(taken));
  always #2.5 mclk_i = ~mclk_i;
  task final_report;
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task chk(input string nm, input logic [12:0] e, input logic [12:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task opt_set(input logic [12:0] w);
    opt_word_i <= w;
    opt_load_i <= 1'b1;
    @(negedge mclk_i) opt_load_i <= 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask
  // Load stays high between calls so words can follow back to back
  task fetch(input logic [12:0] w, input logic s);
    int n;
    n = 0;
    mem_word <= w;
    mem_skip <= s;
    mem_load <= 1'b1;
    do @(negedge mclk_i); while (taken !== 1'b1 && ++n < 40);
    t_prev = t_take;
    t_take = cyc;
    chk("taken", 1'b1, taken);
  endtask
  task stop;
    mem_load <= 1'b0;
    @(negedge mclk_i);
  endtask
  task t_options;
    logic [12:0] ow [4] = '{13'h0025, 13'h1DBA, 13'h1C63, 13'h0F1F};
    for (int i = 0; i < 4; i++) begin
      opt_set(ow[i]);
      chk("osc type", ow[i][12], osc_type_select_o);
      chk("wdt en", !ow[i][11], watchdog_enable_o);
      chk("long cyc", ow[i][10], long_cycle_o);
      chk("protect", !ow[i][9], code_protect_o);
      chk("fast xtal", ow[i][12] & ow[i][8], fast_crystal_mode_o);
      chk("slow xtal", ow[i][12] & !ow[i][8] & !ow[i][7], slow_crystal_mode_o);
      chk("drive", ow[i][7] & !(ow[i][12] & ow[i][8]), drive_power_select_o);
      chk("variant", ow[i][6], variant_a_o);
      chk("rsvd", !ow[i][5] | ow[i][4] | (!ow[i][12] & ow[i][8]), opt_reserved_err_o);
      chk("cust id", ow[i][3:0], customer_id_o);
    end
  endtask
  task t_cycle;
    int n1, n2;
    for (int m = 0; m < 2; m++) begin
      opt_set(m ? 13'h0420 : 13'h0020);
      n1 = 0;
      n2 = 0;
      repeat (16) begin
        @(negedge mclk_i);
        n1 += cycle_end_o;
        n2 += timer_clk_en_o;
      end
      chk("cycle ends", m ? 4 : 8, n1);
      chk("timer ticks", m ? 4 : 8, n2);
    end
  endtask
  task t_timing;
    logic [14:0] tw [6] = '{15'h0000, 15'h4042, 15'h6C00, 15'h0C00, 15'h52B5, 15'h0B6A};
    for (int m = 0; m < 2; m++) begin
      opt_set(m ? 13'h0420 : 13'h0020);
      for (int k = 0; k < 6; k++) begin
        fetch(tw[k][12:0], tw[k][13]);
        chk("two cycle", tw[k][14], two_cycle_o);
        if (k > 0) chk("gap", (tw[k-1][14] ? 2 : 1) * (m ? 4 : 2), t_take - t_prev);
        if (k == 4) chk("literal", 13'h12B5, {lit_wide_o, 2'h0, literal_o});
      end
      chk("bit set", 13'h116A, {bit_set_o, bit_clr_o, bit_test_o, 1'b0, bit_pos_o, reg_sel_o});
      stop;
    end
  endtask
  task t_ops;
    logic [12:0] op [11] = '{13'h0000, 13'h0001, 13'h0002, 13'h0004, 13'h0005, 13'h0010,
      13'h0011, 13'h0012, 13'h0013, 13'h0014, 13'h0003};
    for (int i = 0; i < 11; i++) begin
      fetch(op[i], 1'b0);
      chk("strobe", 11'h400 >> i, {nop_o, decimal_adjust_op_o, ctrl_write_op_o,
        watchdog_clear_op_o, io_ctrl_write_op_o, irq_enable_op_o, irq_disable_op_o, ret_op_o,
        irq_return_op_o, ctrl_read_op_o, sleep_op_o});
      chk("gie", i == 5 || i > 7, gie_o);
      chk("ret two", i == 7 || i == 8, two_cycle_o);
    end
    stop;
    chk("sleep flags", 13'h0003, {pdown_flag_o, tout_flag_o, osc_stop_o});
    chk("opt kept", 1'b1, long_cycle_o);
  endtask
  task t_irq;
    int n;
    n = 0;
    opt_set(13'h0020);
    fetch(13'h0010, 1'b0);
    stop;
    irq_pending_i <= 1'b1;
    do @(negedge mclk_i); while (irq_vector_o !== 1'b1 && ++n < 40);
    chk("vector", 13'h0001, vector_addr_o);
    irq_pending_i <= 1'b0;
    @(negedge mclk_i) chk("gie off", 1'b0, gie_o);
  endtask
  initial begin
    repeat (16) @(negedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i) chk("wdt rst", 1'b0, watchdog_enable_o);
    t_options;
    t_cycle;
    t_timing;
    t_ops;
    t_irq;
    final_report();
  end
endmodule // tb
bind owd_decode owd_decode_sva i_sva (.*);
